// File: swl_pkg.sv
// constants and carrier types for the system register write lock
// assumes one bus clock shared by every user of these definitions
package swl_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned PROT_COUNT = 9;
  localparam int unsigned IDX_W = 4;

  localparam logic [31:0] KEY_FIRST = 32'hAA996655;
  localparam logic [31:0] KEY_SECOND = 32'h556699AA;
  localparam logic [31:0] PROT_RESET = 32'h00000000;
  localparam logic [31:0] KEY_READ_LOCKED = 32'h00000000;
  localparam logic [31:0] KEY_READ_UNLOCKED = 32'h00000001;

  // slot numbers of the protected set inside the store
  localparam logic [3:0] IDX_OSCILLATOR_CONTROL = 4'h0;
  localparam logic [3:0] IDX_PLL_CONTROL = 4'h1;
  localparam logic [3:0] IDX_FAST_RC_TUNING = 4'h2;
  localparam logic [3:0] IDX_MODULE_DISABLE_CONTROL = 4'h3;
  localparam logic [3:0] IDX_SOFTWARE_RESET_TRIGGER = 4'h4;
  localparam logic [3:0] IDX_PIN_SELECT_CONFIG = 4'h5;
  localparam logic [3:0] IDX_NMI_CONTROL = 4'h6;
  localparam logic [3:0] IDX_POWER_CONTROL = 4'h7;
  localparam logic [3:0] IDX_CALENDAR_CONTROL_ONE = 4'h8;

  typedef enum logic [1:0] {
    ST_LOCKED,
    ST_KEY_ONE_SEEN,
    ST_UNLOCKED
  } swl_state_type;

  typedef struct packed {
    logic valid;
    logic [3:0] idx;
    logic [31:0] data;
  } swl_wreq_type;

endpackage

// File: swl_store.sv
// storage for the protected registers, parallel outputs plus a registered read port
// assumes writes arrive already qualified by the lock
module swl_store #(
  parameter int unsigned N = 9,
  parameter int unsigned W = 32,
  parameter int unsigned IW = 4
) (
  input wire logic clk, // bus clock
  input wire logic rst_n, // synchronous reset, low active
  input wire logic wr_en, // qualified write
  input wire logic [IW-1:0] wr_idx, // write slot
  input wire logic [W-1:0] wr_data, // write data
  input wire logic rd_en, // read request
  input wire logic [IW-1:0] rd_idx, // read slot
  output logic [W-1:0] rd_data, // registered read data
  output logic [N*W-1:0] regs // all slots, slot 0 in low bits
);

  logic [W-1:0] mem [N];
  logic [W-1:0] next_mem [N];
  logic [W-1:0] next_rd_data;

  if (N < 1 || N > (1 << IW)) begin : g_bad_n
    $error("swl_store: N does not fit the index width");
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      next_mem[i] = mem[i];
    end
    if (wr_en && (int'(wr_idx) < N)) begin
      next_mem[wr_idx] = wr_data;
    end
    next_rd_data = rd_data;
    if (rd_en) begin
      // out of range slots read as zero
      next_rd_data = (int'(rd_idx) < N) ? mem[rd_idx] : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        mem[i] <= W'(swl_pkg::PROT_RESET);
      end
      rd_data <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        mem[i] <= next_mem[i];
      end
      rd_data <= next_rd_data;
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      regs[i*W +: W] = mem[i];
    end
  end

endmodule // swl_store

// File: swl_lock.sv
// write lock in front of the critical system control registers
// assumes a single bus master on I_MCLK presenting one-cycle write strobes
//
// How it works
// [RQ1] protected writes are dropped while locked; contents stay unchanged
// [RQ2] exact pair first key then second key, back to back, unlocks
// [RQ3] software writes the target register after the pair; accepted while unlocked
// [RQ4] key register write of a non-key value relocks
// [RQ5] software should mask interrupts so nothing splits the two key writes
// [RQ6] key register reads 0 when locked, 1 when unlocked
// [RQ7] nine slots: oscillator, pll, rc tuning, disable, reset, pins, nmi, power, calendar
// [RQ8] an out-of-order key write while locked returns to waiting for the first key; while unlocked, key words keep it open
module swl_lock #(
  parameter int unsigned PROT_N = swl_pkg::PROT_COUNT
) (
  input wire logic I_MCLK, // bus clock, 100 MHz
  input wire logic I_RSTN, // synchronous reset, low active
  input wire logic I_KEY_WR, // key register write strobe
  input wire logic [31:0] I_KEY_WDATA, // key register write data
  input wire swl_pkg::swl_wreq_type I_PROT_WR, // protected register write request
  input wire logic I_OTHER_WR, // write to any unrelated register
  input wire logic I_PROT_RD, // protected register read strobe
  input wire logic [3:0] I_PROT_RD_IDX, // protected register read slot
  output logic [31:0] O_KEY_RDATA, // key register read value, lock status
  output logic O_LOCKED, // lock engaged
  output logic [31:0] O_PROT_RDATA, // protected register read data
  output logic O_PROT_DROPPED, // protected write refused in the previous cycle
  output logic [PROT_N*32-1:0] O_PROT_REGS // protected contents, slot 0 low
);

  // views of the incoming bus writes
  logic key_wr;
  logic [31:0] key_wdata;
  logic prot_wr_valid;
  logic [3:0] prot_wr_idx;
  logic [31:0] prot_wr_data;
  logic other_wr;
  logic key_first_hit;
  logic key_second_hit;
  logic key_word_hit;
  logic pair_breaker;
  logic slot_known;

  // sequence tracker
  swl_pkg::swl_state_type state;
  swl_pkg::swl_state_type next_state;

  // status seen by software
  logic locked;
  logic next_locked;
  logic [31:0] key_rdata;
  logic [31:0] next_key_rdata;

  // refused write report
  logic prot_accept;
  logic store_wr;
  logic dropped;
  logic next_dropped;

  function automatic logic is_first_key(input logic [31:0] word);
    return word == swl_pkg::KEY_FIRST;
  endfunction

  function automatic logic is_second_key(input logic [31:0] word);
    return word == swl_pkg::KEY_SECOND;
  endfunction

  function automatic logic is_key_word(input logic [31:0] word);
    return is_first_key(word) || is_second_key(word);
  endfunction

  // status word for a lock level, never the last written value
  function automatic logic [31:0] status_word(input logic is_locked);
    return is_locked ? swl_pkg::KEY_READ_LOCKED : swl_pkg::KEY_READ_UNLOCKED;
  endfunction

  // the nine registers behind the lock, one store slot each
  function automatic logic is_protected_slot(input logic [3:0] idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      swl_pkg::IDX_OSCILLATOR_CONTROL,
      swl_pkg::IDX_PLL_CONTROL,
      swl_pkg::IDX_FAST_RC_TUNING,
      swl_pkg::IDX_MODULE_DISABLE_CONTROL,
      swl_pkg::IDX_SOFTWARE_RESET_TRIGGER,
      swl_pkg::IDX_PIN_SELECT_CONFIG,
      swl_pkg::IDX_NMI_CONTROL,
      swl_pkg::IDX_POWER_CONTROL,
      swl_pkg::IDX_CALENDAR_CONTROL_ONE: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  if (PROT_N != swl_pkg::PROT_COUNT) begin : g_bad_n
    $error("swl_lock: protected set must hold exactly nine registers");
  end

  if (swl_pkg::DATA_W != 32) begin : g_bad_w
    $error("swl_lock: key and status words are 32 bits wide");
  end

  if ((1 << swl_pkg::IDX_W) < PROT_N) begin : g_bad_idx
    $error("swl_lock: slot index too narrow for the protected set");
  end

  if (int'(swl_pkg::IDX_CALENDAR_CONTROL_ONE) >= PROT_N) begin : g_bad_slot
    $error("swl_lock: named slots do not fit the protected set");
  end

  if (swl_pkg::KEY_FIRST == swl_pkg::KEY_SECOND) begin : g_bad_keys
    $error("swl_lock: the two key words must differ");
  end

  if (swl_pkg::KEY_READ_LOCKED == swl_pkg::KEY_READ_UNLOCKED) begin : g_bad_status
    $error("swl_lock: locked and unlocked status must differ");
  end

  always_comb begin
    key_wr = I_KEY_WR;
    key_wdata = I_KEY_WDATA;
    prot_wr_valid = I_PROT_WR.valid;
    prot_wr_idx = I_PROT_WR.idx;
    prot_wr_data = I_PROT_WR.data;
    other_wr = I_OTHER_WR;
    key_first_hit = key_wr && is_first_key(key_wdata);
    key_second_hit = key_wr && is_second_key(key_wdata);
    key_word_hit = key_wr && is_key_word(key_wdata);
    // any write in a cycle without a key write splits a half-done pair
    pair_breaker = !key_wr && (prot_wr_valid || other_wr);
    slot_known = is_protected_slot(prot_wr_idx); // [RQ7]
  end

  // judged against the current state, so a write in the relocking cycle still lands
  assign prot_accept = prot_wr_valid && (state == swl_pkg::ST_UNLOCKED); // [RQ1] [RQ3]
  // unknown slots are ignored; while unlocked they raise no refusal pulse
  assign store_wr = prot_accept && slot_known; // [RQ7]

  always_comb begin
    next_state = state;
    unique case (state)
      swl_pkg::ST_LOCKED: begin
        // stray second keys and data words leave the lock alone
        if (key_first_hit) begin
          next_state = swl_pkg::ST_KEY_ONE_SEEN; // [RQ2]
        end
      end
      swl_pkg::ST_KEY_ONE_SEEN: begin
        if (key_second_hit) begin
          next_state = swl_pkg::ST_UNLOCKED; // [RQ2]
        end else if (key_wr || pair_breaker) begin
          // a repeated first key also restarts; only the second key advances
          next_state = swl_pkg::ST_LOCKED; // [RQ2] [RQ8]
        end
      end
      swl_pkg::ST_UNLOCKED: begin
        // key words keep it open, so a repeated pair is harmless
        if (key_wr && !key_word_hit) begin
          next_state = swl_pkg::ST_LOCKED; // [RQ4]
        end
      end
    endcase
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      state <= swl_pkg::ST_LOCKED;
    end else begin
      state <= next_state;
    end
  end

  // status follows the next state so it answers one cycle after the key write
  always_comb begin
    next_locked = (next_state != swl_pkg::ST_UNLOCKED);
    next_key_rdata = status_word(next_locked); // [RQ6]
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      locked <= 1'b1;
      key_rdata <= swl_pkg::KEY_READ_LOCKED;
    end else begin
      locked <= next_locked;
      key_rdata <= next_key_rdata;
    end
  end

  always_comb begin
    next_dropped = prot_wr_valid && !prot_accept; // [RQ1]
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      dropped <= 1'b0;
    end else begin
      dropped <= next_dropped;
    end
  end

  assign O_KEY_RDATA = key_rdata; // [RQ6]
  assign O_LOCKED = locked;
  assign O_PROT_DROPPED = dropped;

  swl_store #(
    .N(PROT_N),
    .W(swl_pkg::DATA_W),
    .IW(swl_pkg::IDX_W)
  ) u_store (
    .clk(I_MCLK),
    .rst_n(I_RSTN),
    .wr_en(store_wr), // [RQ7]
    .wr_idx(prot_wr_idx),
    .wr_data(prot_wr_data),
    .rd_en(I_PROT_RD),
    .rd_idx(I_PROT_RD_IDX),
    .rd_data(O_PROT_RDATA),
    .regs(O_PROT_REGS)
  );

endmodule // swl_lock

// File: swl_lock_properties.sv
// checker for swl_lock, bound from the bench
// assumes one clock, synchronous low reset
module swl_lock_chk #(parameter int unsigned PROT_N = 9) (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic I_KEY_WR,
  input wire logic [31:0] I_KEY_WDATA,
  input wire swl_pkg::swl_wreq_type I_PROT_WR,
  input wire logic I_OTHER_WR,
  input wire logic I_PROT_RD,
  input wire logic [3:0] I_PROT_RD_IDX,
  input wire logic [31:0] O_KEY_RDATA,
  input wire logic O_LOCKED,
  input wire logic [31:0] O_PROT_RDATA,
  input wire logic O_PROT_DROPPED,
  input wire logic [PROT_N*32-1:0] O_PROT_REGS
);
  logic k1, k2, nk;
  assign k1 = I_KEY_WR && I_KEY_WDATA == swl_pkg::KEY_FIRST;
  assign k2 = I_KEY_WR && I_KEY_WDATA == swl_pkg::KEY_SECOND;
  // a non-key write relocks from any state, so it anchors the sequences
  assign nk = I_KEY_WR && !k1 && !k2;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  property p_hold; O_LOCKED |=> $stable(O_PROT_REGS); endproperty
  a_hold: assert property (p_hold) else $error("slot changed");
  property p_drop; O_LOCKED && I_PROT_WR.valid |=> O_PROT_DROPPED; endproperty
  a_drop: assert property (p_drop) else $error("no drop");
  property p_unlock; nk ##1 k1 ##1 k2 |=> !O_LOCKED; endproperty
  a_unlock: assert property (p_unlock) else $error("no unlock");
  property p_order; nk ##1 k1 ##1 (k1 || I_OTHER_WR && !I_KEY_WR) ##1 k2 |=> O_LOCKED;
  endproperty
  a_order: assert property (p_order) else $error("bad unlock");
  property p_relock; nk |=> O_LOCKED && O_KEY_RDATA == swl_pkg::KEY_READ_LOCKED; endproperty
  a_relock: assert property (p_relock) else $error("no relock");
  property p_status;
    O_KEY_RDATA == (O_LOCKED ? swl_pkg::KEY_READ_LOCKED : swl_pkg::KEY_READ_UNLOCKED);
  endproperty
  a_status: assert property (p_status) else $error("bad status");
  property p_accept; !O_LOCKED && I_PROT_WR.valid && I_PROT_WR.idx < 4'h9 |=>
    O_PROT_REGS[$past(I_PROT_WR.idx)*32+:32] == $past(I_PROT_WR.data); endproperty
  a_accept: assert property (p_accept) else $error("write lost");
  c_unlock: cover property (nk ##1 k1 ##1 k2);
  c_drop: cover property (O_PROT_DROPPED);
  c_accept: cover property (!O_LOCKED && I_PROT_WR.valid);
endmodule // swl_lock_chk

// File: swl_lock_tb.sv
// bench for swl_lock; checker compiled before
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic I_MCLK = 0, I_RSTN = 0, I_KEY_WR = 0, I_OTHER_WR = 0, I_PROT_RD = 0;
  logic [31:0] I_KEY_WDATA = '0, O_KEY_RDATA, O_PROT_RDATA;
  swl_pkg::swl_wreq_type I_PROT_WR = '0;
  logic [3:0] I_PROT_RD_IDX = '0;
  logic O_LOCKED, O_PROT_DROPPED;
  logic [287:0] O_PROT_REGS;
  int n_errors = 0, check_count = 0, cyc = 0;
  swl_lock #(
    .PROT_N(9)
  ) swl_lock_i (
    .I_MCLK(I_MCLK),
    .I_RSTN(I_RSTN),
    .I_KEY_WR(I_KEY_WR),
    .I_KEY_WDATA(I_KEY_WDATA),
    .I_PROT_WR(I_PROT_WR),
    .I_OTHER_WR(I_OTHER_WR),
    .I_PROT_RD(I_PROT_RD),
    .I_PROT_RD_IDX(I_PROT_RD_IDX),
    .O_KEY_RDATA(O_KEY_RDATA),
    .O_LOCKED(O_LOCKED),
    .O_PROT_RDATA(O_PROT_RDATA),
    .O_PROT_DROPPED(O_PROT_DROPPED),
    .O_PROT_REGS(O_PROT_REGS)
  );
  initial forever #5 I_MCLK = ~I_MCLK;
  task test_done;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // about 100 cycles needed
  always @(posedge I_MCLK) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      test_done;
    end
  end
  task chk(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task chk_flag(input string n, input logic e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s exp %b got %b", n, e, g);
    end
  endtask
  // k: bit0 key, bit1 protected, bit2 other, bit3 read
  task drv(input logic [3:0] k, input logic [31:0] d = '0, input logic [3:0] ix = '0);
    @(negedge I_MCLK);
    I_KEY_WR = k[0];
    I_KEY_WDATA = d;
    I_PROT_WR = '{k[1], ix, d};
    I_OTHER_WR = k[2];
    I_PROT_RD = k[3];
    I_PROT_RD_IDX = ix;
  endtask
  task keys(input logic [31:0] a, b, input logic [3:0] mid);
    drv(4'h1);
    drv(4'h1, swl_pkg::KEY_FIRST);
    drv(mid, a);
    drv(4'h1, b);
    drv(4'h0);
  endtask
  task t_slots;
    for (int i = 0; i < 9; i++) begin
      // fourth key write is a key word, so the gate must stay open
      keys(swl_pkg::KEY_SECOND, swl_pkg::KEY_FIRST, 4'h1);
      chk("key", swl_pkg::KEY_READ_UNLOCKED, O_KEY_RDATA);
      chk_flag("locked", 1'b0, O_LOCKED);
      drv(4'h2, 32'hC0DE0000 + i, i[3:0]);
      drv(4'h1);
      chk_flag("dropped", 1'b0, O_PROT_DROPPED);
      drv(4'h8, 32'h0, i[3:0]);
      drv(4'h0);
      chk("read", 32'hC0DE0000 + i, O_PROT_RDATA);
      chk("key", swl_pkg::KEY_READ_LOCKED, O_KEY_RDATA);
      chk_flag("locked", 1'b1, O_LOCKED);
    end
  endtask
  task t_order;
    keys(swl_pkg::KEY_FIRST, swl_pkg::KEY_SECOND, 4'h1);
    chk("dup", swl_pkg::KEY_READ_LOCKED, O_KEY_RDATA);
    keys(32'h0, swl_pkg::KEY_SECOND, 4'h4);
    chk("other", swl_pkg::KEY_READ_LOCKED, O_KEY_RDATA);
    drv(4'h2, 32'h5A5A5A5A, 4'h3);
    drv(4'h0);
    chk_flag("drop", 1'b1, O_PROT_DROPPED);
    chk_flag("locked", 1'b1, O_LOCKED);
    chk("slot", 32'hC0DE0003, O_PROT_REGS[127:96]);
  endtask
  initial begin
    repeat (6) @(negedge I_MCLK);
    I_RSTN = 1;
    drv(4'h0);
    chk("rst", 32'h0, O_PROT_REGS[287:256]);
    chk("rst key", swl_pkg::KEY_READ_LOCKED, O_KEY_RDATA);
    chk_flag("rst lock", 1'b1, O_LOCKED);
    t_slots;
    t_order;
    test_done;
  end
endmodule // testbench
bind swl_lock swl_lock_chk #(
  .PROT_N(PROT_N)
) swl_lock_chk_i (
  .I_MCLK(I_MCLK),
  .I_RSTN(I_RSTN),
  .I_KEY_WR(I_KEY_WR),
  .I_KEY_WDATA(I_KEY_WDATA),
  .I_PROT_WR(I_PROT_WR),
  .I_OTHER_WR(I_OTHER_WR),
  .I_PROT_RD(I_PROT_RD),
  .I_PROT_RD_IDX(I_PROT_RD_IDX),
  .O_KEY_RDATA(O_KEY_RDATA),
  .O_LOCKED(O_LOCKED),
  .O_PROT_RDATA(O_PROT_RDATA),
  .O_PROT_DROPPED(O_PROT_DROPPED),
  .O_PROT_REGS(O_PROT_REGS)
);
